// ### dv/acfa_host_model.sv
// host-side serial link model: chip select and serial clock
`timescale 1ns/1ps
module acfa_host_model (
   // serial link toward the device
   output logic link_sclk,
   output logic link_cs_n
);
   // ---------------------------------------------------------------
   // idle state
   // ---------------------------------------------------------------
   // clock parks high between frames so the first fall is a real edge
   initial begin
      link_sclk = 1'b1;
      link_cs_n = 1'b1;
   end

   // ---------------------------------------------------------------
   // one frame
   // ---------------------------------------------------------------
   // odd offset keeps the link phase unrelated to the system clock
   task automatic frame();
      link_cs_n <= 1'b0;
      #437;
      repeat (24) begin
         link_sclk = 1'b0;
         #400;
         link_sclk = 1'b1;
         #400;
      end
      link_cs_n = 1'b1;
      #1100;
   endtask : frame
endmodule : acfa_host_model

// ### dv/testbench.sv
// self-checking bench for code formatting, alarms and interrupt
`timescale 1ns/1ps
`include "acfa_regs.svh"
module testbench
   import acfa_pkg::*;
();
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        clock;           // system clock, 100 ns
   logic        sys_rst;         // synchronous reset
   logic [3:0]  avs_address;     // register word index
   logic        avs_read;        // read strobe
   logic        avs_write;       // write strobe
   logic [31:0] avs_writedata;   // write data
   logic [31:0] avs_readdata;    // read data
   logic        avs_waitrequest; // slave stall
   logic        link_sclk;       // serial clock from host model
   logic        link_cs_n;       // chip select from host model
   logic [15:0] sample_raw;      // converter raw sample
   logic [15:0] result_code;     // formatted result
   logic        alarm;           // alarm pin
   logic        irq;             // interrupt line
   logic [31:0] rd;              // last read data
   int          errors;          // mismatches
   int          check_count;     // comparisons
   int          cycles;          // timeout counter

   acfa_core u_dut (.clock, .sys_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .link_sclk, .link_cs_n, .sample_raw, .result_code, .alarm, .irq);

   acfa_host_model u_host (.link_sclk, .link_cs_n);

   // ---------------------------------------------------------------
   // clock and timeout
   // ---------------------------------------------------------------
   always #50 clock = ~clock;

   // whole run needs a few thousand cycles; ceiling leaves margin
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // one bus cycle; request stands until the edge that sees no stall
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   // one link frame with the sample held throughout
   task automatic run(input logic [15:0] raw);
      @(posedge clock);
      sample_raw <= raw;
      u_host.frame();
      @(negedge clock);
   endtask : run

   // expected straight-binary code for a range
   function automatic logic [15:0] fmt(input logic [15:0] raw,
                                       input int rng);
      return (rng < ACFA_RNG_UNI_10V24) ? raw ^ 16'h8000 : raw;
   endfunction : fmt

   // expected high alarm state after a new code
   function automatic bit nxt_hi(input bit cur, input int c, t, h);
      if (c > t + h) return 1'b1;
      if (c <= t - h - 2) return 1'b0;
      return cur;
   endfunction : nxt_hi

   // expected low alarm state after a new code
   function automatic bit nxt_lo(input bit cur, input int c, t, h);
      if (c < t - h - 1) return 1'b1;
      if (c >= t + h + 1) return 1'b0;
      return cur;
   endfunction : nxt_lo

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] raw;
      logic [15:0] ht;
      logic [15:0] hh;
      logic [15:0] lt;
      logic [15:0] lh;
      logic [15:0] c;
      logic [31:0] act;
      logic [31:0] trip;
      int          ch;
      int          cs[8];
      bit          hi;
      bit          lo;
      clock = 1'b0;
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      sample_raw = 16'h0;
      errors = 0;
      check_count = 0;
      cycles = 0;
      void'($urandom(32'h9211B610));
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk(alarm, 32'h0);
      chk(result_code, 32'h0);
      // every range, extreme codes first, on channels 0..8 (aux last)
      for (int r = 0; r < 9; r++) begin
         raw = (r == 0) ? 16'h8000 : (r == 1) ? 16'h7FFF : 16'($urandom);
         bus(1'b1, `ACFA_ADDR_CTRL, {24'h0, 4'(r), 4'(r)});
         run(raw);
         chk(result_code, fmt(raw, r));
      end
      // alarm hysteresis on a random channel, unipolar so code = raw
      ch = $urandom_range(8);
      ht = 16'h8000;
      hh = 16'($urandom_range(64, 1));
      lt = 16'h1000;
      lh = 16'($urandom_range(64, 1));
      bus(1'b1, `ACFA_ADDR_CTRL, {24'h0, 4'(ACFA_RNG_UNI_10V24), 4'(ch)});
      bus(1'b1, `ACFA_ADDR_HIGH_THR, {ht, 12'h0, 4'(ch)});
      bus(1'b1, `ACFA_ADDR_HIGH_HYS, {hh, 12'h0, 4'(ch)});
      bus(1'b1, `ACFA_ADDR_LOW_THR, {lt, 12'h0, 4'(ch)});
      bus(1'b1, `ACFA_ADDR_LOW_HYS, {lh, 12'h0, 4'(ch)});
      // each limit is probed on both sides; last code clears both
      cs = '{ht + hh, ht + hh + 1, ht - hh - 1, ht - hh - 2,
             lt - lh - 1, lt - lh - 2, lt + lh, lt + lh + 1};
      hi = 1'b0;
      lo = 1'b0;
      trip = 32'h0;
      for (int i = 0; i < 12; i++) begin
         c = (i < 4) ? 16'($urandom) : 16'(cs[i - 4]);
         run(c);
         hi = nxt_hi(hi, int'(c), int'(ht), int'(hh));
         lo = nxt_lo(lo, int'(c), int'(lt), int'(lh));
         act = (32'(hi) << (16 + ch)) | (32'(lo) << ch);
         trip = trip | act;
         bus(1'b0, `ACFA_ADDR_ACTIVE, 32'h0);
         chk(rd, act);
         chk(alarm, 32'(trip != 0));
      end
      // host reads the flags; the read clears them
      bus(1'b0, `ACFA_ADDR_TRIPPED, 32'h0);
      chk(rd, trip);
      bus(1'b0, `ACFA_ADDR_TRIPPED, 32'h0);
      chk(rd, 32'h0);
      run(c);
      chk(alarm, 32'h0);
      // trip status unmasked, cleared, then frame-end status
      bus(1'b1, `ACFA_ADDR_IRQ_MASK, 32'h1);
      @(negedge clock);
      chk(irq, 32'h1);
      bus(1'b1, `ACFA_ADDR_IRQ_STAT, 32'h1);
      @(negedge clock);
      chk(irq, 32'h0);
      bus(1'b1, `ACFA_ADDR_IRQ_MASK, 32'h2);
      @(negedge clock);
      chk(irq, 32'h1);
      bus(1'b1, `ACFA_ADDR_IRQ_STAT, 32'h2);
      @(negedge clock);
      chk(irq, 32'h0);
      bus(1'b0, `ACFA_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
      // unmapped word reads as zero
      bus(1'b0, 4'hA, 32'h0);
      chk(rd, 32'h0);
      print_verdict();
   end
endmodule : testbench

// ### rtl/acfa_alarm_cmp.sv
// one channel's high and low alarm comparator with hysteresis
`timescale 1ns/1ps
`include "acfa_regs.svh"
module acfa_alarm_cmp
   import acfa_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // new result for this channel
   input  wire logic        eval,
   input  wire logic [15:0] code,
   // thresholds and hysteresis
   input  wire logic [15:0] high_thr,
   input  wire logic [15:0] high_hys,
   input  wire logic [15:0] low_thr,
   input  wire logic [15:0] low_hys,
   // active flags
   output logic             high_active,
   output logic             low_active
);
   // limits are 18 bits wide with a sign so they never wrap at the code ends
   wire logic signed [17:0] code_s  = {2'b00, code};
   wire logic signed [17:0] hi_up   = $signed({2'b00, high_thr})
                                    + $signed({2'b00, high_hys});
   wire logic signed [17:0] hi_down = $signed({2'b00, high_thr})
                                    - $signed({2'b00, high_hys})
                                    - 18'sd2;
   wire logic signed [17:0] lo_down = $signed({2'b00, low_thr})
                                    - $signed({2'b00, low_hys})
                                    - 18'sd1;
   wire logic signed [17:0] lo_up   = $signed({2'b00, low_thr})
                                    + $signed({2'b00, low_hys})
                                    + 18'sd1;
   // raise and clear decisions
   wire logic hi_set = code_s > hi_up;    // RULE9
   wire logic hi_clr = code_s <= hi_down; // RULE10
   wire logic lo_set = code_s < lo_down;  // RULE11
   wire logic lo_clr = code_s >= lo_up;   // RULE12
   logic high_next;
   logic low_next;
   // hold state between the two limits, that is the hysteresis band
   assign high_next = hi_set ? 1'b1 : (hi_clr ? 1'b0 : high_active);
   assign low_next  = lo_set ? 1'b1 : (lo_clr ? 1'b0 : low_active);

   // flags move only on a fresh result of this channel
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         high_active <= 1'b0;
         low_active  <= 1'b0;
      end else if (eval) begin // RULE18
         high_active <= high_next; // RULE13
         low_active  <= low_next;  // RULE13
      end
   end

   AST_HIGH_RAISE: assert property (@(posedge clock) disable iff (sys_rst)
      eval && hi_set |=> high_active) // RULE9
      else $error("high alarm not raised");
   AST_LOW_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
      eval && lo_clr && !lo_set |=> !low_active) // RULE12
      else $error("low alarm not cleared");
endmodule : acfa_alarm_cmp

// ### rtl/acfa_core.sv
// code formatting, per-channel alarms and alarm pin for the converter
//
// What this block does
// RULE1: results are straight binary, never signed
// RULE2: same code format on every channel
// RULE3: span is positive minus negative full scale
// RULE4: 16-bit codes, step is span over 65536
// RULE5: five bipolar and four unipolar ranges
// RULE6: alarm pin active high, moves at 16th fall
// RULE7: alarm pin high while any tripped flag set
// RULE8: each channel has high and low alarm
// RULE9: high alarm raised above threshold plus hysteresis
// RULE10: high alarm clears at threshold minus hysteresis minus 2
// RULE11: low alarm raised below threshold minus hysteresis minus 1
// RULE12: low alarm clears at threshold plus hysteresis plus 1
// RULE13: active flag follows the alarm condition
// RULE14: tripped flag latches until flag register read
// RULE15: host reads flags after seeing alarm pin
// RULE16: transfers timed on serial clock falling edges
// RULE17: chip select fall starts frame, samples channel
// RULE18: both alarms checked per new unsigned result
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "acfa_regs.svh"
module acfa_core
   import acfa_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // serial link pins from the host
   input  wire logic        link_sclk,
   input  wire logic        link_cs_n,
   // raw sample from the converter core, two's complement for bipolar
   input  wire logic [15:0] sample_raw,
   // outputs
   output logic [15:0]      result_code,
   output logic             alarm,
   output logic             irq
);
   // ------------------------------------------------------------
   // link pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sclk_sync_reg;   // three stages, last two compared
   logic [2:0] cs_sync_reg;
   logic       sclk_state_reg;  // debounced level
   logic       cs_state_reg;

   // sync stage one is read only by stage two
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sclk_sync_reg <= 3'h0;
         cs_sync_reg   <= 3'h7;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], link_sclk};
         cs_sync_reg   <= {cs_sync_reg[1:0], link_cs_n};
      end
   end

   // a level counts only when stages two and three agree
   wire logic sclk_agree = sclk_sync_reg[1] == sclk_sync_reg[2];
   wire logic cs_agree   = cs_sync_reg[1] == cs_sync_reg[2];
   wire logic sclk_fall  = sclk_agree && sclk_state_reg
                           && !sclk_sync_reg[2];
   wire logic cs_fall    = cs_agree && cs_state_reg && !cs_sync_reg[2];
   wire logic cs_rise    = cs_agree && !cs_state_reg && cs_sync_reg[2];

   // filtered levels
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sclk_state_reg <= 1'b0;
         cs_state_reg   <= 1'b1;
      end else begin
         if (sclk_agree)
            sclk_state_reg <= sclk_sync_reg[2];
         if (cs_agree)
            cs_state_reg <= cs_sync_reg[2];
      end
   end

   // ------------------------------------------------------------
   // frame tracking
   // ------------------------------------------------------------
   typedef enum logic [0:0] {ACFA_IDLE, ACFA_FRAME} acfa_state_t;
   acfa_state_t state_reg;
   logic [4:0]  edge_cnt_reg;   // falling edges seen this frame
   wire logic   frame_fall = (state_reg == ACFA_FRAME) && sclk_fall
                             && !cs_state_reg;
   // the 16th falling edge of the frame
   wire logic   edge16 = frame_fall
                         && (edge_cnt_reg == `ACFA_ALARM_EDGE - 5'h01);

   // frame state: counting stops at 16 so later edges do nothing
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg    <= ACFA_IDLE;
         edge_cnt_reg <= 5'h00;
      end else begin
         unique case (state_reg)
            ACFA_IDLE: begin
               if (cs_fall) begin // RULE17
                  state_reg    <= ACFA_FRAME;
                  edge_cnt_reg <= 5'h00;
               end
            end
            ACFA_FRAME: begin
               if (cs_rise)
                  state_reg <= ACFA_IDLE;
               else if (frame_fall && edge_cnt_reg < `ACFA_ALARM_EDGE)
                  edge_cnt_reg <= edge_cnt_reg + 5'h01; // RULE16
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [3:0]  ch_sel_reg;       // channel for next frame
   logic [3:0]  ch_conv_reg;      // channel sampled this frame
   logic        eval_reg;         // one clock after frame start
   logic [15:0] high_thr_reg [`ACFA_NUM_CH];
   logic [15:0] high_hys_reg [`ACFA_NUM_CH];
   logic [15:0] low_thr_reg  [`ACFA_NUM_CH];
   logic [15:0] low_hys_reg  [`ACFA_NUM_CH];
   acfa_range_t range_reg    [`ACFA_NUM_CH];
   logic [8:0]  high_trip_reg;    // tripped flags, latched
   logic [8:0]  low_trip_reg;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_mask_reg;
   logic        alarm_reg;
   logic [15:0] result_reg;

   // selected channel for table access (write data holds channel)
   wire logic [3:0] acc_ch  = avs_writedata[`ACFA_CTRL_CH_LSB +: 4];
   wire logic       wr      = avs_write;
   wire logic       rd      = avs_read;
   wire logic       rd_trip = rd && avs_address == `ACFA_ADDR_TRIPPED;
   wire logic       ch_ok   = acc_ch < 4'(`ACFA_NUM_CH);

   // ------------------------------------------------------------
   // code formatting
   // ------------------------------------------------------------
   // bipolar ranges flip the sign bit: offset binary, lowest code is
   // negative full scale; unipolar raw codes are already straight
   function automatic logic [15:0] fmt_code(input logic [15:0] raw,
                                            input acfa_range_t rng);
      logic bip;
      bip = (rng <= ACFA_RNG_BI_0V64);
      fmt_code = bip ? (raw ^ `ACFA_CODE_MSB) : raw; // RULE1 RULE3
   endfunction : fmt_code

   // the channel chosen during the previous frame is the one sampled now
   wire logic [15:0] conv_code =
      fmt_code(sample_raw, range_reg[ch_sel_reg]); // RULE2 RULE4 RULE5

   // ------------------------------------------------------------
   // alarm comparators, one per channel
   // ------------------------------------------------------------
   logic [8:0] high_active;
   logic [8:0] low_active;
   for (genvar g = 0; g < `ACFA_NUM_CH; g++) begin : g_cmp
      acfa_alarm_cmp u_cmp ( // RULE8
         .clock       (clock),
         .sys_rst     (sys_rst),
         .eval        (eval_reg && ch_conv_reg == 4'(g)),
         .code        (result_reg),
         .high_thr    (high_thr_reg[g]),
         .high_hys    (high_hys_reg[g]),
         .low_thr     (low_thr_reg[g]),
         .low_hys     (low_hys_reg[g]),
         .high_active (high_active[g]),
         .low_active  (low_active[g])
      );
   end

   // tripped flags: set wins over the clearing read
   wire logic [8:0] high_trip_next = (rd_trip ? 9'h000 : high_trip_reg)
                                     | high_active; // RULE14
   wire logic [8:0] low_trip_next  = (rd_trip ? 9'h000 : low_trip_reg)
                                     | low_active;  // RULE14
   wire logic       any_trip = |high_trip_reg || |low_trip_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         high_trip_reg <= 9'h000;
         low_trip_reg  <= 9'h000;
      end else begin
         high_trip_reg <= high_trip_next;
         low_trip_reg  <= low_trip_next;
      end
   end

   // alarm pin only moves on the 16th falling edge
   always_ff @(posedge clock) begin
      if (sys_rst)
         alarm_reg <= 1'b0;
      else if (edge16)
         alarm_reg <= any_trip; // RULE6 RULE7
   end

   // channel latched at frame start; result captured with it, and the
   // comparators look at both one clock later, once they stand
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ch_conv_reg <= 4'h0;
         result_reg  <= 16'h0000;
         eval_reg    <= 1'b0;
      end else begin
         eval_reg <= cs_fall;
         if (cs_fall) begin
            ch_conv_reg <= ch_sel_reg; // RULE17
            result_reg  <= conv_code;
         end
      end
   end

   // interrupt sticky bits: trip and frame end
   wire logic [1:0] irq_ev = {cs_rise, any_trip};
   wire logic [1:0] irq_clr = (wr && avs_address == `ACFA_ADDR_IRQ_STAT)
                              ? avs_writedata[1:0] : 2'h0;
   always_ff @(posedge clock) begin
      if (sys_rst)
         irq_stat_reg <= 2'h0;
      else
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
   end

   // software writes: tables take channel in bits 3:0, value in 31:16
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ch_sel_reg   <= 4'h0;
         irq_mask_reg <= 2'h0;
         for (int i = 0; i < `ACFA_NUM_CH; i++) begin
            high_thr_reg[i] <= `ACFA_THR_HIGH_RST;
            high_hys_reg[i] <= `ACFA_HYS_RST;
            low_thr_reg[i]  <= `ACFA_THR_LOW_RST;
            low_hys_reg[i]  <= `ACFA_HYS_RST;
            range_reg[i]    <= ACFA_RNG_BI_10V24;
         end
      end else if (wr) begin
         unique case (avs_address)
            `ACFA_ADDR_CTRL: begin
               if (ch_ok) begin
                  ch_sel_reg <= acc_ch;
                  range_reg[acc_ch] <= acfa_range_t'(
                     avs_writedata[`ACFA_CTRL_RNG_LSB +: 4]);
               end
            end
            `ACFA_ADDR_HIGH_THR:
               if (ch_ok) high_thr_reg[acc_ch] <= avs_writedata[31:16];
            `ACFA_ADDR_HIGH_HYS:
               if (ch_ok) high_hys_reg[acc_ch] <= avs_writedata[31:16];
            `ACFA_ADDR_LOW_THR:
               if (ch_ok) low_thr_reg[acc_ch] <= avs_writedata[31:16];
            `ACFA_ADDR_LOW_HYS:
               if (ch_ok) low_hys_reg[acc_ch] <= avs_writedata[31:16];
            `ACFA_ADDR_IRQ_MASK:
               irq_mask_reg <= avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // read mux, unmapped reads return zero
   logic [31:0] rdata_next;
   always_comb begin
      unique case (avs_address)
         `ACFA_ADDR_CTRL:
            rdata_next = {24'h0, range_reg[ch_sel_reg], ch_sel_reg};
         `ACFA_ADDR_RESULT:   rdata_next = {16'h0, result_reg};
         `ACFA_ADDR_ACTIVE:
            rdata_next = {7'h0, high_active, 7'h0, low_active};
         `ACFA_ADDR_TRIPPED:  // RULE15
            rdata_next = {7'h0, high_trip_reg, 7'h0, low_trip_reg};
         `ACFA_ADDR_IRQ_STAT: rdata_next = {30'h0, irq_stat_reg};
         `ACFA_ADDR_IRQ_MASK: rdata_next = {30'h0, irq_mask_reg};
         default:             rdata_next = 32'h0000_0000;
      endcase
   end

   // zero wait states: readdata is valid in the request cycle
   assign avs_waitrequest = 1'b0;
   assign avs_readdata    = rdata_next;
   assign result_code     = result_reg;
   assign alarm           = alarm_reg;
   assign irq             = |(irq_stat_reg & irq_mask_reg);

   AST_ALARM_EDGE: assert property (@(posedge clock) disable iff (sys_rst)
      !edge16 |=> $stable(alarm)) // RULE6
      else $error("alarm moved off the 16th edge");
   AST_ALARM_VAL: assert property (@(posedge clock) disable iff (sys_rst)
      edge16 |=> alarm == $past(any_trip)) // RULE7
      else $error("alarm does not follow tripped flags");
   AST_TRIP_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      !rd_trip && |high_trip_reg |=> |high_trip_reg) // RULE14
      else $error("tripped flag lost without read");
   AST_TRIP_SET: assert property (@(posedge clock) disable iff (sys_rst)
      |low_active |=> |low_trip_reg) // RULE14
      else $error("tripped flag not set");
endmodule : acfa_core

// ### rtl/acfa_pkg.sv
// types shared by the alarm block
package acfa_pkg;
   // input range encodings: five bipolar spans, four unipolar spans
   typedef enum logic [3:0] {
      ACFA_RNG_BI_10V24,
      ACFA_RNG_BI_5V12,
      ACFA_RNG_BI_2V56,
      ACFA_RNG_BI_1V28,
      ACFA_RNG_BI_0V64,
      ACFA_RNG_UNI_10V24,
      ACFA_RNG_UNI_5V12,
      ACFA_RNG_UNI_2V56,
      ACFA_RNG_UNI_1V28
   } acfa_range_t;
endpackage : acfa_pkg

// ### rtl/acfa_regs.svh
// register offsets, field positions and timing constants for the alarm block
`ifndef ACFA_REGS_SVH
`define ACFA_REGS_SVH

// register word indices (one per 32-bit word, not byte offsets)
`define ACFA_ADDR_CTRL      4'h0
`define ACFA_ADDR_RESULT    4'h1
`define ACFA_ADDR_HIGH_THR  4'h2
`define ACFA_ADDR_HIGH_HYS  4'h3
`define ACFA_ADDR_LOW_THR   4'h4
`define ACFA_ADDR_LOW_HYS   4'h5
`define ACFA_ADDR_ACTIVE    4'h6
`define ACFA_ADDR_TRIPPED   4'h7
`define ACFA_ADDR_IRQ_STAT  4'h8
`define ACFA_ADDR_IRQ_MASK  4'h9

// channel select and range field inside the control word
`define ACFA_CTRL_CH_LSB    0
`define ACFA_CTRL_RNG_LSB   4
`define ACFA_CH_SEL_W       3

// channel and code sizes
`define ACFA_NUM_CH         9
`define ACFA_CODE_W         16
`define ACFA_CODE_MSB       16'h8000
`define ACFA_CODE_MAX       17'h0FFFF

// serial frame: alarm output moves on this falling edge of the link clock
`define ACFA_ALARM_EDGE     5'h10

// reset values
`define ACFA_THR_HIGH_RST   16'hFFFF
`define ACFA_THR_LOW_RST    16'h0000
`define ACFA_HYS_RST        16'h0000

// interrupt status bits
`define ACFA_IRQ_TRIP_BIT   0
`define ACFA_IRQ_FRAME_BIT  1

`endif
